/* rtl/ddrmr_params.svh */
`ifndef DDRMR_PARAMS_SVH
`define DDRMR_PARAMS_SVH
`define DDRMR_BA_MR1        3'h1
`define DDRMR_BA_MR2        3'h2
`define DDRMR_BA_MR3        3'h3
`define DDRMR_MR1_DLL_OFF   0
`define DDRMR_MR1_AL_LO     3
`define DDRMR_MR1_WLEV      7
`define DDRMR_MR2_PAR_LO    0
`define DDRMR_MR2_WCL_LO    3
`define DDRMR_MR2_AUTO_RATE 6
`define DDRMR_MR2_EXT_TEMP  7
`define DDRMR_MR2_RTTWR_LO  9
`define DDRMR_MR3_LOC_LO    0
`define DDRMR_MR3_PAT_EN    2
`define DDRMR_WCL_BASE      5'h05
`define DDRMR_DLL_OFF_LAT   5'h06
`define DDRMR_CL_RESET      5'h05
`define DDRMR_PATTERN       8'h55
`endif

/* rtl/ddrmr_pkg.sv */
`default_nettype none
package ddrmr_pkg;
    typedef enum logic [1:0] {
        DDRMR_AL_ZERO  = 2'b00,
        DDRMR_AL_CLM1  = 2'b01,
        DDRMR_AL_CLM2  = 2'b10,
        DDRMR_AL_RSVD  = 2'b11
    } ddrmr_al_e;
    typedef enum logic [2:0] {
        DDRMR_CMD_DESEL = 3'b000,
        DDRMR_CMD_NOP   = 3'b001,
        DDRMR_CMD_MRS   = 3'b010,
        DDRMR_CMD_READ  = 3'b011,
        DDRMR_CMD_WRITE = 3'b100,
        DDRMR_CMD_OTHER = 3'b101
    } ddrmr_cmd_e;
    typedef struct packed {
        logic       dll_off;
        logic [1:0] al_code;
        logic       wlev;
        logic [2:0] partial_array_refresh;
        logic [2:0] wcl_code;
        logic       auto_refresh_rate_select;
        logic       extended_temp_refresh_bit;
        logic [1:0] rtt_wr;
        logic [1:0] pat_loc;
        logic       pat_en;
        logic [4:0] write_latency;
        logic [4:0] strobe_latency;
        logic       sr_rate_hot;
        logic       dyn_term_on;
        logic       nom_only;
        logic       read_from_pattern;
        logic       write_accept;
        logic       read_accept;
        logic [7:0] read_pattern;
    } ddrmr_state_s;
endpackage
`default_nettype wire

/* rtl/ddrmr_mode_regs.sv */
`include "ddrmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddrmr_mode_regs
    import ddrmr_pkg::*;
#(
    parameter int CL_W = 5
) (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            cs_n,
    input  wire logic            ras_n,
    input  wire logic            cas_n,
    input  wire logic            we_n,
    input  wire logic [2:0]      bank,
    input  wire logic [13:0]     addr,
    input  wire logic [CL_W-1:0] cas_latency,
    input  wire logic            thermal_hot,
    output logic                 dll_off,
    output logic [CL_W-1:0]      write_latency,
    output logic [CL_W-1:0]      strobe_latency,
    output logic [2:0]           partial_array_refresh,
    output logic                 auto_refresh_rate_select,
    output logic                 extended_temp_refresh_bit,
    output logic                 sr_rate_hot,
    output logic [1:0]           rtt_wr,
    output logic                 dyn_term_on,
    output logic                 nom_only,
    output logic                 pat_en,
    output logic [1:0]           pat_loc,
    output logic                 read_from_pattern,
    output logic [7:0]           read_pattern,
    output logic                 write_accept,
    output logic                 read_accept
);
    ddrmr_state_s st;
    ddrmr_state_s next_st;
    ddrmr_cmd_e   cmd;
    logic [4:0]   al_cyc;
    logic [4:0]   wcl_cyc;
    logic [4:0]   rl_cyc;

    // command decode; deselect and no-operation start nothing
    always_comb begin
        if (cs_n) begin
            cmd = DDRMR_CMD_DESEL;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'b111:  cmd = DDRMR_CMD_NOP;
                3'b000:  cmd = DDRMR_CMD_MRS;
                3'b101:  cmd = DDRMR_CMD_READ;
                3'b100:  cmd = DDRMR_CMD_WRITE;
                default: cmd = DDRMR_CMD_OTHER;
            endcase
        end
    end

    // next state: register writes, then latencies and derived behaviour
    always_comb begin
        next_st = st;
        if (cmd == DDRMR_CMD_MRS) begin
            case (bank)
                `DDRMR_BA_MR1: begin
                    next_st.dll_off = addr[`DDRMR_MR1_DLL_OFF];
                    next_st.al_code = addr[`DDRMR_MR1_AL_LO +: 2];
                    next_st.wlev    = addr[`DDRMR_MR1_WLEV];
                end
                `DDRMR_BA_MR2: begin
                    next_st.partial_array_refresh =
                        addr[`DDRMR_MR2_PAR_LO +: 3];
                    next_st.wcl_code = addr[`DDRMR_MR2_WCL_LO +: 3];
                    next_st.auto_refresh_rate_select =
                        addr[`DDRMR_MR2_AUTO_RATE];
                    next_st.extended_temp_refresh_bit =
                        addr[`DDRMR_MR2_EXT_TEMP];
                    next_st.rtt_wr = addr[`DDRMR_MR2_RTTWR_LO +: 2];
                end
                `DDRMR_BA_MR3: begin
                    next_st.pat_en  = addr[`DDRMR_MR3_PAT_EN];
                    next_st.pat_loc = addr[`DDRMR_MR3_LOC_LO +: 2];
                end
                default: begin
                end
            endcase
        end
        // latency arithmetic from the fields as they will stand
        wcl_cyc = `DDRMR_WCL_BASE + {2'h0, next_st.wcl_code};
        if (next_st.dll_off) begin
            wcl_cyc = `DDRMR_DLL_OFF_LAT;
        end
        case (ddrmr_al_e'(next_st.al_code))
            DDRMR_AL_ZERO: al_cyc = 5'h00;
            DDRMR_AL_CLM1: al_cyc = 5'(cas_latency) - 5'h01;
            DDRMR_AL_CLM2: al_cyc = 5'(cas_latency) - 5'h02;
            default:       al_cyc = 5'h00;
        endcase
        rl_cyc = al_cyc + 5'(cas_latency);
        next_st.write_latency = al_cyc + wcl_cyc;
        // one cycle earlier strobe with the lock loop off
        next_st.strobe_latency = next_st.dll_off ?
            rl_cyc - 5'h01 : rl_cyc;
        // self refresh rate source
        next_st.sr_rate_hot = next_st.auto_refresh_rate_select ?
            thermal_hot : next_st.extended_temp_refresh_bit;
        // write termination independent of nominal; leveling blocks it
        next_st.nom_only    = next_st.wlev;
        next_st.dyn_term_on = (next_st.rtt_wr != 2'h0) &&
                              !next_st.wlev;
        next_st.write_accept = (cmd == DDRMR_CMD_WRITE);
        next_st.read_accept  = (cmd == DDRMR_CMD_READ);
        next_st.read_from_pattern = (cmd == DDRMR_CMD_READ) &&
                                    st.pat_en;
        // location only matters while readout is on
        if (next_st.pat_en) begin
            next_st.read_pattern = `DDRMR_PATTERN >> next_st.pat_loc;
        end else begin
            next_st.read_pattern = 8'h00;
        end
    end

    // state register; reset works in every mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
            st.write_latency  <= `DDRMR_WCL_BASE;
            st.strobe_latency <= `DDRMR_CL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign dll_off                   = st.dll_off;
    assign write_latency             = CL_W'(st.write_latency);
    assign strobe_latency            = CL_W'(st.strobe_latency);
    assign partial_array_refresh     = st.partial_array_refresh;
    assign auto_refresh_rate_select  = st.auto_refresh_rate_select;
    assign extended_temp_refresh_bit = st.extended_temp_refresh_bit;
    assign sr_rate_hot               = st.sr_rate_hot;
    assign rtt_wr                    = st.rtt_wr;
    assign dyn_term_on               = st.dyn_term_on;
    assign nom_only                  = st.nom_only;
    assign pat_en                    = st.pat_en;
    assign pat_loc                   = st.pat_loc;
    assign read_from_pattern         = st.read_from_pattern;
    assign read_pattern              = st.read_pattern;
    assign write_accept              = st.write_accept;
    assign read_accept               = st.read_accept;
endmodule
`default_nettype wire

/* verif/ddrmr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrmr_ctrl_model (
    input  wire logic   sys_clk,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [2:0]  bank,
    output logic [13:0] addr
);
    // bus starts deselected, then idles at no-operation after each command
    initial {cs_n, ras_n, cas_n, we_n, bank, addr} = 21'h1FFFFF;
    // one command for one edge, reserved MR2 and MR3 mode bits low
    task automatic issue(input logic [3:0] c, input logic [2:0] b,
                         input logic [13:0] a);
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        bank <= b;
        addr <= (c != 4'h0) ? a : (b == 3'h2) ? a & 14'h06FF
              : (b == 3'h3) ? a & 14'h0007 : a;
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        addr <= ~a; // stale bus shows no old value
    endtask
endmodule
`default_nettype wire

/* verif/ddrmr_mode_regs_properties.sv */
`include "ddrmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ddrmr_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  bank,
    input wire logic [13:0] addr,
    input wire logic        thermal_hot,
    input wire logic        auto_refresh_rate_select,
    input wire logic        extended_temp_refresh_bit,
    input wire logic        sr_rate_hot,
    input wire logic [1:0]  rtt_wr,
    input wire logic        dyn_term_on,
    input wire logic        nom_only,
    input wire logic        pat_en,
    input wire logic [1:0]  pat_loc,
    input wire logic        read_from_pattern,
    input wire logic [7:0]  read_pattern
);
    // command decode
    wire logic mrs = !cs_n && !ras_n && !cas_n && !we_n;
    wire logic rd = !cs_n && ras_n && !cas_n && we_n;
    wire logic nop = !cs_n && ras_n && cas_n && we_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    term_field_a: assert property (mrs && bank == 3'h2 |=>
        rtt_wr == $past(addr[10:9])) else $error("bad rtt");
    mr3_field_a: assert property (mrs && bank == 3'h3 |=>
        pat_en == $past(addr[2]) && pat_loc == $past(addr[1:0]))
        else $error("bad pattern fields");
    rate_source_a: assert property (!$past(rst) |-> sr_rate_hot ==
        (auto_refresh_rate_select ? $past(thermal_hot)
        : extended_temp_refresh_bit)) else $error("bad rate");
    term_gate_a: assert property (dyn_term_on ==
        (rtt_wr != 2'h0 && !nom_only)) else $error("bad termination");
    pattern_out_a: assert property (read_pattern ==
        (pat_en ? `DDRMR_PATTERN >> pat_loc : 8'h00)) else $error("bad data");
    desel_hold_a: assert property (!rst && cs_n |=> $stable(rtt_wr)
        && $stable(pat_en) && $stable(pat_loc)) else $error("deselect");
    nop_hold_a: assert property (!rst && nop |=> $stable(rtt_wr)
        && $stable(pat_en)) else $error("nop changed state");
    pat_read_a: assert property (rd && pat_en |->
        ##[1:2] read_from_pattern) else $error("no pattern read");
    reset_clear_a: assert property ($fell(rst) |-> !pat_en
        && rtt_wr == 2'h0) else $error("reset not applied");
    cover property (mrs && bank == 3'h2);
    cover property (mrs && bank == 3'h3 && addr[2]);
    cover property (read_from_pattern);
endmodule
bind ddrmr_mode_regs ddrmr_props ddrmr_props_i (.*);
`default_nettype wire

/* verif/ddrmr_mode_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrmr_mode_regs_test;
    logic        sys_clk, rst, thermal_hot, cs_n, ras_n, cas_n, we_n;
    logic        dll_off, sr_rate_hot, dyn_term_on, nom_only, pat_en;
    logic        auto_refresh_rate_select, extended_temp_refresh_bit;
    logic        read_from_pattern, write_accept, read_accept;
    logic [1:0]  rtt_wr, pat_loc;
    logic [2:0]  bank, partial_array_refresh;
    logic [4:0]  cas_latency, write_latency, strobe_latency;
    logic [7:0]  read_pattern, pulses, al, rd_pulses, wr_pulses;
    logic [13:0] addr;
    int          fail_count = 0;
    int          checks_done = 0;
    ddrmr_ctrl_model ddrmr_ctrl_model_i (.*);
    ddrmr_mode_regs ddrmr_mode_regs_i (.*);
    // clock and read and write strobe counters
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (read_from_pattern === 1'b1) pulses <= pulses + 8'h01;
        if (read_accept === 1'b1) rd_pulses <= rd_pulses + 8'h01;
        if (write_accept === 1'b1) wr_pulses <= wr_pulses + 8'h01;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one bus command, then settle past its answer
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                       input logic [13:0] a);
        ddrmr_ctrl_model_i.issue(c, b, a);
        @(posedge sys_clk);
        #1;
    endtask
    // main sequence
    initial begin
        {rst, thermal_hot, cas_latency, pulses} = {7'h45, 8'h00};
        {rd_pulses, wr_pulses} = 16'h0000;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        cmd(4'h5, 3'h0, 14'h0000);
        chk(write_latency, 8'h05);
        cmd(4'h0, 3'h2, 14'h029D);
        chk(write_latency, 8'h08);
        chk(partial_array_refresh, 8'h05);
        chk(sr_rate_hot, 8'h01);
        chk(dyn_term_on, 8'h01);
        cmd(4'h4, 3'h0, 14'h0000);
        cmd(4'h8, 3'h2, 14'h0000);
        cmd(4'h7, 3'h2, 14'h0000);
        chk(rtt_wr, 8'h01);
        for (int i = 0; i < 4; i++) begin
            cmd(4'h0, 3'h1, {6'h00, 1'b1, 2'h0, i[1:0], 3'h0});
            al = (i == 1) ? 8'h04 : (i == 2) ? 8'h03 : 8'h00;
            chk(write_latency, 8'h08 + al);
            chk(strobe_latency, 8'h05 + al);
            chk(dyn_term_on, 8'h00);
            chk(nom_only, 8'h01);
        end
        cmd(4'h0, 3'h2, 14'h00C0);
        chk(auto_refresh_rate_select, 8'h01);
        chk(extended_temp_refresh_bit, 8'h01);
        chk(sr_rate_hot, 8'h00);
        @(posedge sys_clk);
        thermal_hot <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(sr_rate_hot, 8'h01);
        cmd(4'h0, 3'h3, 14'h0003);
        chk(read_pattern, 8'h00);
        chk(pat_loc, 8'h03);
        cmd(4'h0, 3'h3, 14'h0006);
        chk(read_pattern, 8'h15);
        cmd(4'h5, 3'h0, 14'h0000);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        cas_latency <= 5'h06;
        cmd(4'h0, 3'h2, 14'h0008);
        chk(pulses, 8'h01);
        chk(rd_pulses, 8'h02);
        chk(wr_pulses, 8'h01);
        chk(pat_en, 8'h00);
        cmd(4'h0, 3'h1, 14'h0001);
        chk(dll_off, 8'h01);
        chk(write_latency, 8'h06);
        chk(strobe_latency, 8'h05);
        cmd(4'h0, 3'h1, 14'h0000);
        chk(dll_off, 8'h00);
        chk(strobe_latency, 8'h06);
        end_of_test;
    end
endmodule
`default_nettype wire
